// file: rtl/period_timer_pkg.sv
/*
 * Package for the 8-bit period match timer.
 * Holds register indices, field positions, reset values and timing counts.
 * Assumes a plain register port with 8-bit data in the low byte.
 */
package period_timer_pkg;

	// Register indices, word offsets on the plain port
	localparam logic [3:0] ADDR_TIMER_COUNT    = 4'h0;
	localparam logic [3:0] ADDR_PERIOD_VALUE   = 4'h1;
	localparam logic [3:0] ADDR_TIMER_CONTROL  = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CONTROL    = 4'h3;
	localparam logic [3:0] ADDR_LINK_CONTROL   = 4'h4;
	localparam logic [3:0] ADDR_STATUS         = 4'h5;

	// Timer control fields
	localparam int CTRL_PRESCALE_LSB  = 0;
	localparam int CTRL_RUN_BIT       = 2;
	localparam int CTRL_POSTSCALE_LSB = 3;

	// Interrupt control fields
	localparam int IRQ_FLAG_BIT     = 0;
	localparam int IRQ_ENABLE_BIT   = 1;
	localparam int IRQ_PRIORITY_BIT = 2;

	// Link control fields
	localparam int LINK_DISABLE_BIT = 0;
	localparam int LINK_TSEL_LSB    = 1;

	// Reset values
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] PERIOD_RESET  = 8'hFF;
	localparam logic [6:0] CONTROL_RESET = 7'h00;

	// Prescale select codes
	localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
	localparam logic [3:0] PRESCALE_MAX4  = 4'h3;
	localparam logic [3:0] PRESCALE_MAX16 = 4'hF;

	// Serial port mode code that selects the timer shift clock
	localparam logic [3:0] SERIAL_MODE_TIMER = 4'h3;

	// Instruction clock is one quarter of the oscillator clock
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

	// Timebase select code owned by this timer instance
	localparam logic [1:0] TIMEBASE_OWN = 2'h1;

endpackage : period_timer_pkg

// file: rtl/scaler_counter.sv
/*
 * Wrapping scaler counter with a terminal count input.
 * Assumes clear and advance come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module scaler_counter (
	input  wire logic       ref_clk_i,  // System clock
	input  wire logic       sys_rst_i,  // Sync reset, active high
	input  wire logic       clk_en_i,   // Global clock enable
	input  wire logic       clear_i,    // Synchronous clear
	input  wire logic       step_i,     // Advance by one
	input  wire logic [3:0] last_i,     // Terminal count
	output logic            wrap_o,     // Step at terminal, combinational
	output logic      [3:0] count_o     // Current count
);
	typedef struct packed {
		logic [3:0] cnt;
	} scaler_state_t;

	scaler_state_t state_reg;
	scaler_state_t state_next;

	// Next count: clear wins, wrap at terminal
	always_comb begin
		state_next = state_reg;
		wrap_o = step_i && (state_reg.cnt >= last_i);
		if (clear_i) begin
			state_next.cnt = 4'h0;
		end else if (step_i) begin
			state_next.cnt = wrap_o ? 4'h0 : state_reg.cnt + 4'h1;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	assign count_o = state_reg.cnt;
endmodule // scaler_counter
`default_nettype wire

// file: rtl/sync_level.sv
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_level (
	input  wire logic ref_clk_i,  // System clock
	input  wire logic sys_rst_i,  // Sync reset, active high
	input  wire logic async_i,    // Raw level
	output logic      sync_o      // Synchronised level
);
	typedef struct packed {
		logic meta;
		logic sync;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// Shift chain
	always_comb begin
		state_next.meta = async_i;
		state_next.sync = state_reg.meta;
	end

	// Free-running so the chain settles even when frozen
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_o = state_reg.sync;
endmodule // sync_level
`default_nettype wire

// file: rtl/period_match_timer_8bit.sv
/*
 * Top of the 8-bit period match timer with prescaler and postscaler.
 * Holds register port, instruction clock divider, count, compare and flag.
 * Assumes the plain register port is driven on ref_clk_i by on-chip logic,
 * and that sleep and serial mode inputs arrive from other domains.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
// Overview of operation
// - Timer ticks only on instruction clock, oscillator clock divided by four.
// - Count starts at zero, adds one per prescaler output tick.
// - Four-bit prescaler passes ticks, or divides by four or sixteen.
// - Count compared with period each tick; equality gives match pulse.
// - The matching tick itself clears count and advances the postscaler.
// - Reset clears count and sets period to all ones.
// - Writing count or control clears prescaler and postscaler.
// - All device resets clear both scaler counters.
// - Control write leaves the count unchanged.
// - Postscaler output sets the match flag, which stays latched.
// - Interrupt request only while flag and enable are both set.
// - A priority bit selects the interrupt level.
// - Sixteen postscale ratios chosen by a four-bit field.
// - Unscaled match offered as PWM timebase per unit select field.
// - First instance gives serial shift clock when mode equals 0011.
// - During sleep only the instruction clock divider counts; count and period hold.
// - Module disable holds timer in reset and removes its clock.
// - Software reads count and period at any time, and writes them unless module disable is set.
// - Prescale 00 is one, 01 is four, 1x is sixteen.
// - Postscale value n flags once per n+1 matches.
// - Run bit set lets timer run, cleared stops it.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_8bit
	import period_timer_pkg::*;
#(
	parameter bit FIRST_INSTANCE = 1'b1  // Instance that may clock the serial port
) (
	input  wire logic       ref_clk_i,          // 100 MHz oscillator clock
	input  wire logic       sys_rst_i,          // Any device reset, sync, high
	input  wire logic       clk_en_i,           // Freezes all state but the input synchronisers when low
	input  wire logic [3:0] reg_addr_i,         // Register index
	input  wire logic [7:0] reg_wdata_i,        // Write data
	input  wire logic       reg_wr_i,           // Write strobe
	input  wire logic       reg_rd_i,           // Read strobe
	input  wire logic       sleep_i,            // Processor sleep, asynchronous
	input  wire logic [3:0] serial_mode_i,      // Serial port mode field, asynchronous
	input  wire logic [1:0] pwm_timebase_sel_i, // PWM unit timebase select, same domain
	output logic      [7:0] reg_rdata_o,        // Read data, cycle after strobe
	output logic            match_o,            // Unscaled match pulse
	output logic            pwm_timebase_o,     // Match routed to the PWM unit
	output logic            shift_clk_o,        // Serial port shift clock
	output logic            irq_o,              // Interrupt request level
	output logic            irq_high_prio_o     // Request uses high priority
);
	typedef struct packed {
		logic [1:0] instr_div;
		logic [7:0] timer_count;
		logic [7:0] period_value;
		logic [1:0] clock_prescale_select;
		logic       timer_run;
		logic [3:0] output_postscale_select;
		logic       match_irq_flag;
		logic       match_irq_enable;
		logic       match_irq_priority;
		logic       first_timer_disable;
		logic       clear_pending;
		logic [7:0] rdata;
		logic       match;
		logic       timebase;
		logic       shift_clk;
		logic       irq;
		logic       irq_prio;
	} timer_state_t;

	timer_state_t state_reg;
	timer_state_t state_next;

	logic       sleep_sync;
	logic [3:0] mode_sync;
	logic       instr_tick;
	logic       active;
	logic       pre_wrap;
	logic       post_wrap;
	logic       scaler_clear;
	logic       is_match;
	logic       wr_count;
	logic       wr_control;
	logic [3:0] pre_last;
	logic [3:0] pre_count;
	logic [3:0] post_count;
	logic [6:0] control_view;

	// Pin-side inputs pass two flip-flops
	sync_level u_sleep_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (sleep_i),
		.sync_o    (sleep_sync)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mode_sync
			sync_level u_mode_sync (
				.ref_clk_i (ref_clk_i),
				.sys_rst_i (sys_rst_i),
				.async_i   (serial_mode_i[gi]),
				.sync_o    (mode_sync[gi])
			);
		end
	endgenerate

	// Decoded strobes
	assign wr_count   = reg_wr_i && (reg_addr_i == ADDR_TIMER_COUNT);
	assign wr_control = reg_wr_i && (reg_addr_i == ADDR_TIMER_CONTROL);

	// Timer counts only when on, awake and enabled
	assign active = state_reg.timer_run && !sleep_sync
		&& !state_reg.first_timer_disable;
	assign instr_tick = (state_reg.instr_div == INSTR_DIV_LAST);

	// Prescale decode
	always_comb begin
		pre_last = 4'h0;
		if (state_reg.clock_prescale_select == PRESCALE_DIV1) begin
			pre_last = 4'h0;
		end else if (state_reg.clock_prescale_select == PRESCALE_DIV4) begin
			pre_last = PRESCALE_MAX4;
		end else begin
			pre_last = PRESCALE_MAX16;
		end
	end

	// Scaler clears on count or control writes and module disable; reset clears inside
	assign scaler_clear = wr_count || wr_control
		|| state_reg.first_timer_disable;

	// Prescaler counter on instruction ticks
	scaler_counter u_prescaler (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i  (clk_en_i),
		.clear_i   (scaler_clear),
		.step_i    (instr_tick && active),
		.last_i    (pre_last),
		.wrap_o    (pre_wrap),
		.count_o   (pre_count)
	);

	// Compare on each prescaled tick
	assign is_match = pre_wrap
		&& (state_reg.timer_count == state_reg.period_value);

	// Postscaler counts match pulses
	scaler_counter u_postscaler (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i  (clk_en_i),
		.clear_i   (scaler_clear),
		.step_i    (is_match),
		.last_i    (state_reg.output_postscale_select),
		.wrap_o    (post_wrap),
		.count_o   (post_count)
	);

	assign control_view = {state_reg.output_postscale_select,
		state_reg.timer_run, state_reg.clock_prescale_select};

	// Register file, counting and outputs
	always_comb begin
		state_next = state_reg;
		state_next.clear_pending = 1'b0;
		// Instruction clock divider, held with module disable
		if (state_reg.first_timer_disable) begin
			state_next.instr_div = 2'h0;
		end else begin
			state_next.instr_div = state_reg.instr_div + 2'h1;
		end
		// Count: clear after a match, else step on each prescaled tick
		if (is_match) begin
			state_next.timer_count = COUNT_RESET;
		end else if (pre_wrap) begin
			state_next.timer_count = state_reg.timer_count + 8'h01;
		end
		// Hardware sets the flag
		if (post_wrap) begin
			state_next.match_irq_flag = 1'b1;
		end
		// Software writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_TIMER_COUNT: begin
					state_next.timer_count = reg_wdata_i;
				end
				ADDR_PERIOD_VALUE: begin
					state_next.period_value = reg_wdata_i;
				end
				ADDR_TIMER_CONTROL: begin
					// Count untouched here
					state_next.clock_prescale_select =
						reg_wdata_i[CTRL_PRESCALE_LSB +: 2];
					state_next.timer_run = reg_wdata_i[CTRL_RUN_BIT];
					state_next.output_postscale_select =
						reg_wdata_i[CTRL_POSTSCALE_LSB +: 4];
				end
				ADDR_IRQ_CONTROL: begin
					// Set from hardware wins over a software clear
					state_next.match_irq_flag = post_wrap
						|| reg_wdata_i[IRQ_FLAG_BIT];
					state_next.match_irq_enable = reg_wdata_i[IRQ_ENABLE_BIT];
					state_next.match_irq_priority = reg_wdata_i[IRQ_PRIORITY_BIT];
				end
				ADDR_LINK_CONTROL: begin
					state_next.first_timer_disable = reg_wdata_i[LINK_DISABLE_BIT];
				end
				default: begin
					state_next.clear_pending = 1'b0;
				end
			endcase
		end
		// Module disable holds timer state in reset
		if (state_reg.first_timer_disable) begin
			state_next.timer_count = COUNT_RESET;
			state_next.period_value = PERIOD_RESET;
			state_next.clock_prescale_select = 2'h0;
			state_next.timer_run = 1'b0;
			state_next.output_postscale_select = 4'h0;
			state_next.match_irq_flag = 1'b0;
		end
		// Read data for the cycle after the strobe
		state_next.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_TIMER_COUNT:   state_next.rdata = state_reg.timer_count;
				ADDR_PERIOD_VALUE:  state_next.rdata = state_reg.period_value;
				ADDR_TIMER_CONTROL: state_next.rdata = {1'b0, control_view};
				ADDR_IRQ_CONTROL: begin
					state_next.rdata = {5'h00, state_reg.match_irq_priority,
						state_reg.match_irq_enable, state_reg.match_irq_flag};
				end
				ADDR_LINK_CONTROL: begin
					state_next.rdata = {7'h00, state_reg.first_timer_disable};
				end
				ADDR_STATUS:        state_next.rdata = {post_count, pre_count};
				default:            state_next.rdata = 8'h00;
			endcase
		end
		// Registered outputs
		state_next.match = is_match;
		state_next.timebase = is_match
			&& (pwm_timebase_sel_i == TIMEBASE_OWN);
		state_next.shift_clk = FIRST_INSTANCE && is_match
			&& (mode_sync == SERIAL_MODE_TIMER);
		state_next.irq = state_next.match_irq_flag
			&& state_next.match_irq_enable;
		state_next.irq_prio = state_next.match_irq_priority;
	end

	// State register; reset also clears scalers inside submodules
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
			state_reg.timer_count <= COUNT_RESET;
			state_reg.period_value <= PERIOD_RESET;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_o     = state_reg.rdata;
	assign match_o         = state_reg.match;
	assign pwm_timebase_o  = state_reg.timebase;
	assign shift_clk_o     = state_reg.shift_clk;
	assign irq_o           = state_reg.irq;
	assign irq_high_prio_o = state_reg.irq_prio;
endmodule // period_match_timer_8bit
`default_nettype wire

// file: verif/period_timer_sva.sv
/*
 * Checker for the period match timer top, seen at its ports only.
 * Assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module period_timer_sva
	import period_timer_pkg::*;
#(
	parameter bit FIRST_INSTANCE = 1'b1  // Same as the design
) (
	input wire logic       ref_clk_i,       // Clock
	input wire logic       sys_rst_i,       // Reset
	input wire logic       clk_en_i,        // Enable
	input wire logic [3:0] reg_addr_i,      // Address
	input wire logic [7:0] reg_wdata_i,     // Write data
	input wire logic       reg_wr_i,        // Write strobe
	input wire logic       reg_rd_i,        // Read strobe
	input wire logic       sleep_i,         // Sleep
	input wire logic [7:0] reg_rdata_o,     // Read data
	input wire logic       match_o,         // Match
	input wire logic       pwm_timebase_o,  // Timebase
	input wire logic       shift_clk_o,     // Shift clock
	input wire logic       irq_o,           // Request
	input wire logic       irq_high_prio_o  // Priority
);
	logic       run_reg, dis_reg, en_reg, prio_reg;
	logic [2:0] slp_reg;

	// Shadow of software control bits and sleep length
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			{run_reg, dis_reg, en_reg, prio_reg, slp_reg} <= '0;
		end else begin
			slp_reg <= !sleep_i ? 3'h0 : (slp_reg == 3'h7 ? slp_reg : slp_reg + 3'h1);
			if (clk_en_i && reg_wr_i) begin
				if (reg_addr_i == ADDR_TIMER_CONTROL) run_reg <= reg_wdata_i[CTRL_RUN_BIT];
				if (reg_addr_i == ADDR_LINK_CONTROL) dis_reg <= reg_wdata_i[LINK_DISABLE_BIT];
				if (reg_addr_i == ADDR_IRQ_CONTROL) begin
					en_reg   <= reg_wdata_i[IRQ_ENABLE_BIT];
					prio_reg <= reg_wdata_i[IRQ_PRIORITY_BIT];
				end
			end
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside answer cycle");
	reset_quiet_a: assert property ($past(sys_rst_i) |-> !match_o && !irq_o && !irq_high_prio_o)
		else $error("outputs not cleared by reset");
	match_gap_a: assert property (match_o |=> !match_o [*3])
		else $error("matches closer than one instruction clock");
	timebase_gate_a: assert property (pwm_timebase_o |-> match_o)
		else $error("timebase pulse without match");
	shift_gate_a: assert property (shift_clk_o |-> match_o && FIRST_INSTANCE)
		else $error("shift clock without match");
	run_hold_a: assert property (!run_reg && !$past(run_reg) && !$past(run_reg, 2) |-> !match_o)
		else $error("match while timer off");
	disable_hold_a: assert property (dis_reg && $past(dis_reg) && $past(dis_reg, 2) |-> !match_o)
		else $error("match while disabled");
	sleep_hold_a: assert property (slp_reg >= 3'h5 |-> !match_o)
		else $error("match during sleep");
	irq_mask_a: assert property (!en_reg && !$past(en_reg) |-> !irq_o)
		else $error("request while masked");
	prio_follow_a: assert property ($rose(prio_reg) |-> ##[0:2] irq_high_prio_o)
		else $error("priority level not taken");
endmodule // period_timer_sva
`default_nettype wire

// file: verif/serial_pwm_model.sv
/*
 * Far-side model: a PWM unit and a serial port that count timer pulses.
 * Assumes the bench sets the mode and select it wants.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_pwm_model (
	input  wire logic       ref_clk_i,      // Clock
	input  wire logic       clear_i,        // Clear counts
	input  wire logic [3:0] mode_req_i,     // Wanted serial mode
	input  wire logic [1:0] sel_req_i,      // Wanted timebase
	input  wire logic       shift_clk_i,    // Shift clock in
	input  wire logic       pwm_timebase_i, // Timebase in
	output logic      [3:0] serial_mode_o,  // Serial mode field
	output logic      [1:0] timebase_sel_o, // Timebase select field
	output logic      [7:0] shift_cnt_o,    // Shift pulses seen
	output logic      [7:0] pwm_cnt_o       // Timebase pulses seen
);
	// Register the fields and count pulses each unit receives
	always_ff @(posedge ref_clk_i) begin
		serial_mode_o  <= mode_req_i;
		timebase_sel_o <= sel_req_i;
		shift_cnt_o    <= clear_i ? 8'h00 : shift_cnt_o + {7'h00, shift_clk_i};
		pwm_cnt_o      <= clear_i ? 8'h00 : pwm_cnt_o + {7'h00, pwm_timebase_i};
	end
endmodule // serial_pwm_model
`default_nettype wire

// file: verif/tb_period_match_timer_8bit.sv
/*
 * Self-checking bench for the period match timer with far-side model.
 * Assumes 100 MHz clock and the register map of the timer package.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_period_match_timer_8bit;
	import period_timer_pkg::*;
	logic       ref_clk_i, sys_rst_i, clk_en_i, wr_s, rd_s, sleep_s, clr_s;
	logic [3:0] addr, mode_req, mode_w;
	logic [7:0] wdata, rdata, shift_cnt, pwm_cnt, v, v2;
	logic [1:0] sel_req, sel_w;
	logic       match_w, pwm_w, shift_w, irq_w, prio_w;
	int         n_mismatch, n_compared, t;

	period_match_timer_8bit dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .sleep_i(sleep_s), .serial_mode_i(mode_w), .pwm_timebase_sel_i(sel_w),
		.reg_rdata_o(rdata), .match_o(match_w), .pwm_timebase_o(pwm_w),
		.shift_clk_o(shift_w), .irq_o(irq_w), .irq_high_prio_o(prio_w));
	serial_pwm_model partner (.ref_clk_i(ref_clk_i), .clear_i(clr_s), .mode_req_i(mode_req),
		.sel_req_i(sel_req), .shift_clk_i(shift_w), .pwm_timebase_i(pwm_w),
		.serial_mode_o(mode_w), .timebase_sel_o(sel_w), .shift_cnt_o(shift_cnt),
		.pwm_cnt_o(pwm_cnt));

	// Clock and hang guard
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#300us;
		n_mismatch++;
		results();
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a; wdata <= d; wr_s <= 1'b1;
		@(posedge ref_clk_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a; rd_s <= 1'b1;
		@(posedge ref_clk_i);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// Cycles from one match to the next, less one, bounded
	task automatic wait_match(output int n);
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1 n++;
		end while (match_w !== 1'b1 && n < 2000);
		n--;
	endtask
	task automatic results();
		$display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic t_reset();
		rd(ADDR_TIMER_COUNT, v); chk(v, COUNT_RESET);
		rd(ADDR_PERIOD_VALUE, v); chk(v, PERIOD_RESET);
		rd(ADDR_STATUS, v); chk(v, 8'h00);
		rd(4'hF, v); chk(v, 8'h00);
		wr(ADDR_PERIOD_VALUE, 8'h5A); rd(ADDR_PERIOD_VALUE, v); chk(v, 8'h5A);
		wr(ADDR_TIMER_COUNT, 8'hA5); rd(ADDR_TIMER_COUNT, v); chk(v, 8'hA5);
	endtask
	// Match spacing for every prescale code, period 3
	task automatic t_prescale();
		int div [4] = '{1, 4, 16, 16};
		wr(ADDR_PERIOD_VALUE, 8'h03);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_TIMER_CONTROL, 8'h04 | 8'(c));
			wait_match(t);
			wait_match(t);
			chk(8'(t), 8'(16 * div[c] - 1));
		end
	endtask
	// Flag after n+1 matches, then mask, priority and clear
	task automatic t_post();
		logic [3:0] ns [3] = '{4'h0, 4'h2, 4'hF};
		wr(ADDR_PERIOD_VALUE, 8'h01);
		foreach (ns[i]) begin
			wr(ADDR_TIMER_CONTROL, {1'b0, ns[i], 3'h0});
			wr(ADDR_IRQ_CONTROL, 8'h02);
			// Count from zero so only the ns[i] awaited matches land before the first flag read
			wr(ADDR_TIMER_COUNT, 8'h00);
			wr(ADDR_TIMER_CONTROL, {1'b0, ns[i], 3'h4});
			repeat (ns[i]) wait_match(t);
			rd(ADDR_IRQ_CONTROL, v); chk(v, 8'h02);
			wait_match(t);
			repeat (2) @(posedge ref_clk_i);
			rd(ADDR_IRQ_CONTROL, v); chk(v, 8'h03);
			chk({7'h00, irq_w}, 8'h01);
		end
		wr(ADDR_IRQ_CONTROL, 8'h05);
		repeat (3) @(posedge ref_clk_i);
		chk({6'h00, prio_w, irq_w}, 8'h02);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd(ADDR_IRQ_CONTROL, v); chk(v, 8'h05);
		wr(ADDR_IRQ_CONTROL, 8'h00); rd(ADDR_IRQ_CONTROL, v); chk(v, 8'h00);
	endtask
	// Stopped, control write, sleep and disable
	task automatic t_hold();
		rd(ADDR_TIMER_COUNT, v);
		repeat (50) @(posedge ref_clk_i);
		rd(ADDR_TIMER_COUNT, v2); chk(v2, v);
		wr(ADDR_TIMER_CONTROL, 8'h06);
		repeat (30) @(posedge ref_clk_i);
		wr(ADDR_TIMER_CONTROL, 8'h02);
		rd(ADDR_STATUS, v); chk(v, 8'h00);
		wr(ADDR_TIMER_COUNT, 8'h2A); wr(ADDR_TIMER_CONTROL, 8'h02);
		rd(ADDR_TIMER_COUNT, v); chk(v, 8'h2A);
		wr(ADDR_PERIOD_VALUE, 8'hFF); wr(ADDR_TIMER_CONTROL, 8'h04);
		sleep_s <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		rd(ADDR_TIMER_COUNT, v);
		repeat (40) @(posedge ref_clk_i);
		rd(ADDR_TIMER_COUNT, v2); chk(v2, v);
		sleep_s <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		rd(ADDR_TIMER_COUNT, v2); chk({7'h00, v2 !== v}, 8'h01);
		wr(ADDR_LINK_CONTROL, 8'h01);
		rd(ADDR_TIMER_COUNT, v); chk(v, COUNT_RESET);
		rd(ADDR_PERIOD_VALUE, v); chk(v, PERIOD_RESET);
		wr(ADDR_LINK_CONTROL, 8'h00);
	endtask
	// Pulses reach the far side only when selected
	task automatic t_link(input logic [3:0] m, input logic [1:0] s, input bit on);
		mode_req <= m; sel_req <= s;
		wr(ADDR_PERIOD_VALUE, 8'h00); wr(ADDR_TIMER_CONTROL, 8'h04);
		repeat (4) @(posedge ref_clk_i);
		clr_s <= 1'b1;
		@(posedge ref_clk_i);
		clr_s <= 1'b0;
		repeat (100) @(posedge ref_clk_i);
		chk({7'h00, shift_cnt != 0}, {7'h00, on});
		chk({7'h00, pwm_cnt != 0}, {7'h00, on});
	endtask

	// Main sequence with a second reset mid-run
	initial begin
		{sys_rst_i, clk_en_i, wr_s, rd_s, sleep_s, clr_s} = 6'b110000;
		{addr, wdata, mode_req, sel_req} = '0;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_prescale();
		t_post();
		t_hold();
		t_link(SERIAL_MODE_TIMER, TIMEBASE_OWN, 1'b1);
		t_link(4'h5, 2'h2, 1'b0);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(ADDR_PERIOD_VALUE, v); chk(v, PERIOD_RESET);
		rd(ADDR_STATUS, v); chk(v, 8'h00);
		results();
	end
endmodule // tb_period_match_timer_8bit

bind period_match_timer_8bit period_timer_sva #(.FIRST_INSTANCE(FIRST_INSTANCE)) u_sva (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .sleep_i(sleep_i), .reg_rdata_o(reg_rdata_o), .match_o(match_o),
	.pwm_timebase_o(pwm_timebase_o), .shift_clk_o(shift_clk_o), .irq_o(irq_o),
	.irq_high_prio_o(irq_high_prio_o));
`default_nettype wire
